// File: inc/scfg_consts.svh
`ifndef SCFG_CONSTS_SVH
`define SCFG_CONSTS_SVH

// command codes
`define SCFG_OFS_VOUT_FORMAT 8'h20
`define SCFG_OFS_VOUT_NOMINAL 8'h21
`define SCFG_OFS_VOUT_UPPER 8'h24
`define SCFG_OFS_VOUT_MARGIN_HI 8'h25
`define SCFG_OFS_VOUT_MARGIN_LO 8'h26
`define SCFG_OFS_VOUT_OV_FAULT 8'h40
`define SCFG_OFS_VOUT_OV_WARN 8'h42
`define SCFG_OFS_VOUT_UV_WARN 8'h43
`define SCFG_OFS_VOUT_UV_FAULT 8'h44
`define SCFG_OFS_VOUT_CEILING 8'ha5
`define SCFG_OFS_VIN_OV_FAULT 8'h55
`define SCFG_OFS_VIN_UV_WARN 8'h58
`define SCFG_OFS_VIN_START 8'h35
`define SCFG_OFS_VIN_STOP 8'h36
`define SCFG_OFS_VIN_FILTER 8'hf7
`define SCFG_OFS_PHASE_CFG 8'he0
`define SCFG_OFS_SWITCH_FREQ 8'he1

// reset values
`define SCFG_RST_VOUT_FORMAT 8'h16
`define SCFG_RST_VOUT_NOMINAL 16'h1400
`define SCFG_RST_VOUT_UPPER 16'ha000
`define SCFG_RST_VOUT_MARGIN_HI 16'h1500
`define SCFG_RST_VOUT_MARGIN_LO 16'h1300
`define SCFG_RST_VOUT_OV_FAULT 16'h1600
`define SCFG_RST_VOUT_OV_WARN 16'h1580
`define SCFG_RST_VOUT_UV_WARN 16'h1280
`define SCFG_RST_VOUT_UV_FAULT 16'h1200
`define SCFG_RST_VOUT_CEILING 16'ha200
`define SCFG_RST_VIN_OV_FAULT 16'he300
`define SCFG_RST_VIN_UV_WARN 16'hcb26
`define SCFG_RST_VIN_START 16'hcb40
`define SCFG_RST_VIN_STOP 16'hcb00
`define SCFG_RST_VIN_FILTER 16'h0be8
`define SCFG_RST_PHASE_CFG 8'h00
`define SCFG_RST_SWITCH_FREQ 16'h00fa

// phase config field positions
`define SCFG_PH_SHARED_FB 7
`define SCFG_PH_GAIN_HI 6
`define SCFG_PH_GAIN_LO 5
`define SCFG_PH_SHARE_CLK 4
`define SCFG_PH_SEL_HI 2

// switching frequency bounds in kHz
`define SCFG_FREQ_MIN 16'h0055
`define SCFG_FREQ_MAX 16'h01f4

`endif

// File: inc/scfg_pkg.sv
package scfg_pkg;

   // one command transfer from the serial-bus transaction layer
   typedef struct packed {
      logic write;
      logic page;
      logic [7:0] code;
      logic [15:0] wdata;
   } scfg_cmd_type;

   // answer to one command transfer
   typedef struct packed {
      logic ack;
      logic [15:0] rdata;
   } scfg_rsp_type;

   // phase offsets in degrees for both channels
   typedef struct packed {
      logic [8:0] ch0;
      logic [8:0] ch1;
   } scfg_phase_type;

   // sticky status flags
   typedef struct packed {
      logic input_ov_fault;
      logic input_uv_warn;
      logic word_input;
      logic busy_fault;
      logic comm_fault;
      logic [1:0] output_upper_limit_warn;
      logic pll_unlock;
   } scfg_status_type;

   typedef enum logic [1:0] {
      SCFG_WAIT_START = 2'b00,
      SCFG_CONVERTING = 2'b01
   } scfg_conv_type;

endpackage

// File: hw/scfg_l11_cmp.sv
`timescale 1ns/1ps

// compares two words in five-bit exponent, eleven-bit mantissa form
module scfg_l11_cmp (
   input wire logic [15:0] a,
   input wire logic [15:0] b,
   output logic a_gt_b,
   output logic a_lt_b
);

   // scale by 2^16 so every exponent becomes a plain left shift
   function automatic logic signed [47:0] to_fix(input logic [15:0] w);
      logic signed [47:0] m;
      logic [4:0] sh;
      m = {{37{w[10]}}, w[10:0]};
      sh = {~w[15], w[14:11]}; // exponent plus sixteen
      return m <<< sh;
   endfunction

   logic signed [47:0] fa;
   logic signed [47:0] fb;

   // R12
   always_comb begin
      fa = to_fix(a);
      fb = to_fix(b);
      a_gt_b = fa > fb;
      a_lt_b = fa < fb;
   end

endmodule // scfg_l11_cmp

// File: hw/scfg_bank.sv
`timescale 1ns/1ps
`include "scfg_consts.svh"

// What the document asks of this block and its host
// R1 - phase field decodes to channel 0 and channel 1 offsets per table
// R2 - host sets shared-feedback bit only when channels are tied together
// R3 - frequency writes between 85 and 500 kHz inclusive are accepted
// R4 - part counts as off when run is low or both channels off
// R5 - frequency write while running is refused, busy fault, value kept
// R6 - frequency change while off may flag loop unlocked until relock
// R7 - input above overvoltage limit (code 0x55) raises input fault
// R8 - undervoltage warning armed only after start threshold and enable
// R9 - undervoltage warning sets word input bit, input bit, and alert
// R10 - conversion starts above start threshold, stops below stop threshold
// R11 - host writes zero filter resistance when no filter is fitted
// R12 - input limits are two bytes, signed exponent and signed mantissa
// R13 - output format byte read-only at 0x20, reads 0x16
// R14 - commanded output never exceeds per-channel upper limit at 0x24
// R15 - nominal setpoint per channel at 0x21, default 0x1400
// R16 - host keeps margin-high (0x25) above nominal setpoint
// R17 - host keeps margin-low (0x26) below nominal setpoint
// R18 - output overvoltage fault 0x40 and warning 0x42 limits per channel
// R19 - output undervoltage warning 0x43 and fault 0x44 limits per channel
// R20 - ceiling readback word read-only at 0xa5, reads 0xa200
// R21 - format byte holds linear mode field and five-bit exponent
// R22 - nominal above ceiling: communication fault, warning bit, clamp
// R23 - output commands per page, input commands shared by channels
// R24 - output words are unsigned mantissas scaled by format exponent
module scfg_bank (
   input wire logic REF_CLK,
   input wire logic SRST,
   input wire logic CMD_VALID,
   input wire scfg_pkg::scfg_cmd_type CMD,
   output logic RSP_VALID,
   output scfg_pkg::scfg_rsp_type RSP,
   input wire logic RUN_PIN,
   input wire logic [1:0] CHAN_ON,
   input wire logic [1:0] MARGIN_HIGH_SEL,
   input wire logic [1:0] MARGIN_LOW_SEL,
   input wire logic [15:0] VIN_MEAS,
   input wire logic PLL_LOCKED,
   input wire logic ALERT_MASK,
   input wire logic STATUS_CLEAR,
   output logic [15:0] SWITCH_FREQ_KHZ,
   output scfg_pkg::scfg_phase_type PHASE,
   output logic SHARED_FEEDBACK,
   output logic [1:0] SENSE_GAIN,
   output logic SHARE_CLK_ENABLE,
   output logic [15:0] INPUT_FILTER_RES,
   output logic [1:0][15:0] VOUT_TARGET,
   output logic CONVERT_EN,
   output scfg_pkg::scfg_status_type STATUS,
   output logic ALERT_DO,
   output logic ALERT_OE
);

   localparam int VOUT_REGS = 8;
   localparam int VIN_REGS = 5;

   // map an output-voltage code to its slot in the paged store
   function automatic logic [3:0] vout_slot(input logic [7:0] code);
      unique case (code)
         `SCFG_OFS_VOUT_NOMINAL: return 4'h8;
         `SCFG_OFS_VOUT_UPPER: return 4'h9;
         `SCFG_OFS_VOUT_MARGIN_HI: return 4'ha;
         `SCFG_OFS_VOUT_MARGIN_LO: return 4'hb;
         `SCFG_OFS_VOUT_OV_FAULT: return 4'hc;
         `SCFG_OFS_VOUT_OV_WARN: return 4'hd;
         `SCFG_OFS_VOUT_UV_WARN: return 4'he;
         `SCFG_OFS_VOUT_UV_FAULT: return 4'hf;
         default: return 4'h0; // bit 3 clear means no slot
      endcase
   endfunction

   // map an input-voltage code to its slot in the shared store
   function automatic logic [3:0] vin_slot(input logic [7:0] code);
      unique case (code)
         `SCFG_OFS_VIN_OV_FAULT: return 4'h8;
         `SCFG_OFS_VIN_UV_WARN: return 4'h9;
         `SCFG_OFS_VIN_START: return 4'ha;
         `SCFG_OFS_VIN_STOP: return 4'hb;
         `SCFG_OFS_VIN_FILTER: return 4'hc;
         default: return 4'h0;
      endcase
   endfunction

   function automatic logic [15:0] vout_default(input int i);
      unique case (i)
         0: return `SCFG_RST_VOUT_NOMINAL;
         1: return `SCFG_RST_VOUT_UPPER;
         2: return `SCFG_RST_VOUT_MARGIN_HI;
         3: return `SCFG_RST_VOUT_MARGIN_LO;
         4: return `SCFG_RST_VOUT_OV_FAULT;
         5: return `SCFG_RST_VOUT_OV_WARN;
         6: return `SCFG_RST_VOUT_UV_WARN;
         default: return `SCFG_RST_VOUT_UV_FAULT;
      endcase
   endfunction

   function automatic logic [15:0] vin_default(input int i);
      unique case (i)
         0: return `SCFG_RST_VIN_OV_FAULT;
         1: return `SCFG_RST_VIN_UV_WARN;
         2: return `SCFG_RST_VIN_START;
         3: return `SCFG_RST_VIN_STOP;
         default: return `SCFG_RST_VIN_FILTER;
      endcase
   endfunction

   function automatic logic [15:0] umin(input logic [15:0] a,
                                        input logic [15:0] b);
      return (a < b) ? a : b; // R24
   endfunction

   // phase offsets in degrees; the unused code falls back to 0/180
   function automatic scfg_pkg::scfg_phase_type
      phase_decode(input logic [2:0] sel);
      unique case (sel)
         3'h0: return {9'h000, 9'h0b4};
         3'h1: return {9'h05a, 9'h10e};
         3'h2: return {9'h000, 9'h0f0};
         3'h3: return {9'h000, 9'h078};
         3'h4: return {9'h078, 9'h0f0};
         3'h5: return {9'h03c, 9'h0f0};
         3'h6: return {9'h078, 9'h12c};
         default: return {9'h000, 9'h0b4};
      endcase
   endfunction

   // ---- run pin synchroniser
   logic [2:0] run_sync;
   logic run_q;
   logic [2:0] next_run_sync;
   logic next_run_q;

   // a pin change counts only once stages two and three agree
   always_comb begin
      next_run_sync = {run_sync[1:0], RUN_PIN};
      next_run_q = run_q;
      if (run_sync[1] == run_sync[2]) begin
         next_run_q = run_sync[2];
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         run_sync <= 3'h0;
         run_q <= 1'b0;
      end else begin
         run_sync <= next_run_sync;
         run_q <= next_run_q;
      end
   end

   logic part_off;
   logic unit_enabled;
   assign part_off = !run_q || (CHAN_ON == 2'h0); // R4
   assign unit_enabled = run_q && (CHAN_ON != 2'h0);

   // ---- command registers
   logic [15:0] vout_reg [2][VOUT_REGS];
   logic [15:0] vin_reg [VIN_REGS];
   logic [7:0] phase_cfg;
   logic [15:0] freq;
   logic [15:0] next_vout_reg [2][VOUT_REGS];
   logic [15:0] next_vin_reg [VIN_REGS];
   logic [7:0] next_phase_cfg;
   logic [15:0] next_freq;
   logic next_rsp_valid;
   scfg_pkg::scfg_rsp_type next_rsp;
   logic ev_busy;
   logic ev_comm;
   logic [1:0] ev_vmax;
   logic ev_freq_change;
   logic [3:0] vo_slot;
   logic [3:0] vi_slot;

   // decode one transfer; the answer comes one cycle after the request
   always_comb begin
      next_vout_reg = vout_reg;
      next_vin_reg = vin_reg;
      next_phase_cfg = phase_cfg;
      next_freq = freq;
      next_rsp_valid = CMD_VALID;
      next_rsp = '0;
      ev_busy = 1'b0;
      ev_comm = 1'b0;
      ev_vmax = 2'h0;
      ev_freq_change = 1'b0;
      vo_slot = vout_slot(CMD.code);
      vi_slot = vin_slot(CMD.code);
      if (CMD_VALID) begin
         next_rsp.ack = 1'b1;
         if (vo_slot[3]) begin
            // R23
            if (CMD.write) begin
               next_vout_reg[CMD.page][vo_slot[2:0]] = CMD.wdata; // R15 R18 R19
               if ((vo_slot[2:0] == 3'h0) &&
                   (CMD.wdata > `SCFG_RST_VOUT_CEILING)) begin
                  // R22
                  next_vout_reg[CMD.page][0] = `SCFG_RST_VOUT_CEILING;
                  ev_comm = 1'b1;
                  ev_vmax[CMD.page] = 1'b1;
               end
            end else begin
               next_rsp.rdata = vout_reg[CMD.page][vo_slot[2:0]];
            end
         end else if (vi_slot[3]) begin
            // R23
            if (CMD.write) begin
               next_vin_reg[vi_slot[2:0]] = CMD.wdata; // R12
            end else begin
               next_rsp.rdata = vin_reg[vi_slot[2:0]];
            end
         end else begin
            unique case (CMD.code)
               `SCFG_OFS_VOUT_FORMAT: begin
                  next_rsp.rdata = {8'h00, `SCFG_RST_VOUT_FORMAT}; // R13 R21
                  if (CMD.write) begin
                     next_rsp.ack = 1'b0;
                     ev_comm = 1'b1;
                  end
               end
               `SCFG_OFS_VOUT_CEILING: begin
                  next_rsp.rdata = `SCFG_RST_VOUT_CEILING; // R20
                  if (CMD.write) begin
                     next_rsp.ack = 1'b0;
                     ev_comm = 1'b1;
                  end
               end
               `SCFG_OFS_SWITCH_FREQ: begin
                  next_rsp.rdata = freq;
                  if (CMD.write && !part_off) begin
                     next_rsp.ack = 1'b0; // R5
                     ev_busy = 1'b1; // R5
                  end else if (CMD.write &&
                               (CMD.wdata >= `SCFG_FREQ_MIN) &&
                               (CMD.wdata <= `SCFG_FREQ_MAX)) begin
                     next_freq = CMD.wdata; // R3
                     ev_freq_change = (CMD.wdata != freq); // R6
                  end else if (CMD.write) begin
                     next_rsp.ack = 1'b0;
                     ev_comm = 1'b1;
                  end
               end
               `SCFG_OFS_PHASE_CFG: begin
                  next_rsp.rdata = {8'h00, phase_cfg};
                  if (CMD.write && !part_off) begin
                     next_rsp.ack = 1'b0; // R4
                     ev_busy = 1'b1;
                  end else if (CMD.write) begin
                     next_phase_cfg = CMD.wdata[7:0];
                  end
               end
               default: begin
                  // unknown code: refuse and flag
                  next_rsp.ack = 1'b0;
                  ev_comm = 1'b1;
               end
            endcase
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < VOUT_REGS; i++) begin
               vout_reg[p][i] <= vout_default(i);
            end
         end
         for (int i = 0; i < VIN_REGS; i++) begin
            vin_reg[i] <= vin_default(i);
         end
         phase_cfg <= `SCFG_RST_PHASE_CFG;
         freq <= `SCFG_RST_SWITCH_FREQ;
         RSP_VALID <= 1'b0;
         RSP <= '0;
      end else begin
         vout_reg <= next_vout_reg;
         vin_reg <= next_vin_reg;
         phase_cfg <= next_phase_cfg;
         freq <= next_freq;
         RSP_VALID <= next_rsp_valid;
         RSP <= next_rsp;
      end
   end

   // ---- input supervision
   logic vin_gt_ov;
   logic vin_lt_uvw;
   logic vin_gt_on;
   logic vin_lt_off;

   scfg_l11_cmp u_cmp_ov (
      .a(VIN_MEAS),
      .b(vin_reg[0]),
      .a_gt_b(vin_gt_ov),
      .a_lt_b()
   );

   scfg_l11_cmp u_cmp_uvw (
      .a(VIN_MEAS),
      .b(vin_reg[1]),
      .a_gt_b(),
      .a_lt_b(vin_lt_uvw)
   );

   scfg_l11_cmp u_cmp_on (
      .a(VIN_MEAS),
      .b(vin_reg[2]),
      .a_gt_b(vin_gt_on),
      .a_lt_b()
   );

   scfg_l11_cmp u_cmp_off (
      .a(VIN_MEAS),
      .b(vin_reg[3]),
      .a_gt_b(),
      .a_lt_b(vin_lt_off)
   );

   scfg_pkg::scfg_conv_type conv_state;
   scfg_pkg::scfg_conv_type next_conv_state;
   logic uv_armed;
   logic next_uv_armed;

   // start/stop hysteresis; the warning stays quiet until armed
   always_comb begin
      next_conv_state = conv_state;
      next_uv_armed = uv_armed;
      unique case (conv_state)
         scfg_pkg::SCFG_WAIT_START: begin
            next_uv_armed = 1'b0;
            if (vin_gt_on) begin
               next_conv_state = scfg_pkg::SCFG_CONVERTING; // R10
            end
         end
         scfg_pkg::SCFG_CONVERTING: begin
            if (unit_enabled) begin
               next_uv_armed = 1'b1; // R8
            end
            if (vin_lt_off) begin
               next_conv_state = scfg_pkg::SCFG_WAIT_START; // R10
               next_uv_armed = 1'b0;
            end
         end
         default: begin
            next_conv_state = scfg_pkg::SCFG_WAIT_START;
            next_uv_armed = 1'b0;
         end
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         conv_state <= scfg_pkg::SCFG_WAIT_START;
         uv_armed <= 1'b0;
      end else begin
         conv_state <= next_conv_state;
         uv_armed <= next_uv_armed;
      end
   end

   // ---- sticky status; a new event beats a clear in the same cycle
   scfg_pkg::scfg_status_type next_status;
   logic pll_seen_low;
   logic next_pll_seen_low;
   logic next_alert;
   logic ev_uv_warn;

   always_comb begin
      ev_uv_warn = uv_armed && vin_lt_uvw; // R8
      next_status = STATUS_CLEAR ? '0 : STATUS;
      next_pll_seen_low = pll_seen_low || !PLL_LOCKED;
      if (ev_freq_change) begin
         next_pll_seen_low = 1'b0;
      end
      if (vin_gt_ov) begin
         next_status.input_ov_fault = 1'b1; // R7
      end
      if (ev_uv_warn) begin
         next_status.input_uv_warn = 1'b1; // R9
         next_status.word_input = 1'b1; // R9
      end
      if (ev_busy) begin
         next_status.busy_fault = 1'b1;
      end
      if (ev_comm) begin
         next_status.comm_fault = 1'b1;
      end
      next_status.output_upper_limit_warn = next_status.output_upper_limit_warn | ev_vmax;
      // unlock clears on a status clear, or once a relock follows a visible drop
      if (STATUS.pll_unlock && pll_seen_low && PLL_LOCKED) begin
         next_status.pll_unlock = 1'b0;
      end
      if (ev_freq_change) begin
         next_status.pll_unlock = 1'b1; // R6
      end
      next_alert = |next_status[7:1] && !ALERT_MASK; // R9
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         STATUS <= '0;
         pll_seen_low <= 1'b0;
         ALERT_OE <= 1'b0;
      end else begin
         STATUS <= next_status;
         pll_seen_low <= next_pll_seen_low;
         ALERT_OE <= next_alert;
      end
   end

   // open-drain alert only ever pulls low
   assign ALERT_DO = 1'b0;

   // ---- registered outputs to the power stage
   logic [1:0][15:0] next_target;
   logic [15:0] sel;

   // margin requests can never push past either ceiling
   always_comb begin
      next_target = '0;
      sel = 16'h0000;
      for (int c = 0; c < 2; c++) begin
         sel = vout_reg[c][0];
         if (MARGIN_HIGH_SEL[c]) begin
            sel = vout_reg[c][2];
         end else if (MARGIN_LOW_SEL[c]) begin
            sel = vout_reg[c][3];
         end
         next_target[c] = umin(umin(sel, vout_reg[c][1]),
                               `SCFG_RST_VOUT_CEILING); // R14
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         VOUT_TARGET <= '0;
         PHASE <= '0;
         SHARED_FEEDBACK <= 1'b0;
         SENSE_GAIN <= 2'h0;
         SHARE_CLK_ENABLE <= 1'b0;
         SWITCH_FREQ_KHZ <= 16'h0000;
         INPUT_FILTER_RES <= 16'h0000;
         CONVERT_EN <= 1'b0;
      end else begin
         VOUT_TARGET <= next_target;
         PHASE <= phase_decode(phase_cfg[`SCFG_PH_SEL_HI:0]); // R1
         SHARED_FEEDBACK <= phase_cfg[`SCFG_PH_SHARED_FB];
         SENSE_GAIN <= phase_cfg[`SCFG_PH_GAIN_HI:`SCFG_PH_GAIN_LO];
         SHARE_CLK_ENABLE <= phase_cfg[`SCFG_PH_SHARE_CLK];
         SWITCH_FREQ_KHZ <= freq;
         INPUT_FILTER_RES <= vin_reg[4];
         CONVERT_EN <= (conv_state == scfg_pkg::SCFG_CONVERTING); // R10
      end
   end

endmodule // scfg_bank

// File: tb/scfg_bank_assertions.sv
`timescale 1ns/1ps
module scfg_bank_assertions (
   input wire logic REF_CLK,
   input wire logic SRST,
   input wire logic CMD_VALID,
   input wire scfg_pkg::scfg_cmd_type CMD,
   input wire logic RSP_VALID,
   input wire scfg_pkg::scfg_rsp_type RSP,
   input wire logic RUN_PIN,
   input wire logic [1:0] CHAN_ON,
   input wire logic ALERT_MASK,
   input wire logic STATUS_CLEAR,
   input wire logic [1:0][15:0] VOUT_TARGET,
   input wire scfg_pkg::scfg_status_type STATUS,
   input wire logic ALERT_DO,
   input wire logic ALERT_OE
);
   logic [2:0] run_cnt;
   logic [2:0] next_run_cnt;

   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SRST);

   // run pin passes a 3-flop synchroniser, so count how long it stood high
   always_comb begin
      next_run_cnt = run_cnt;
      if (!RUN_PIN) next_run_cnt = 3'h0;
      else if (run_cnt != 3'h7) next_run_cnt = run_cnt + 3'h1;
   end
   always_ff @(posedge REF_CLK) begin
      if (SRST) run_cnt <= 3'h0;
      else run_cnt <= next_run_cnt;
   end

   // write of the switching-frequency code
   sequence s_freq_write;
      CMD_VALID && CMD.write && CMD.code == 8'he1 && !STATUS_CLEAR;
   endsequence
   sequence s_refused(logic flag);
      !RSP.ack && flag;
   endsequence

   a_rsp_one_cycle: assert property (CMD_VALID |=> RSP_VALID)
      else $error("answer missing one cycle after command");
   a_rsp_no_cause: assert property (!CMD_VALID |=> !RSP_VALID)
      else $error("answer without command");
   a_freq_range_nack: assert property (s_freq_write ##0 CHAN_ON == 2'h0
      ##0 (CMD.wdata < 16'h0055 || CMD.wdata > 16'h01f4)
      |=> s_refused(STATUS.comm_fault))
      else $error("out of range frequency accepted");
   a_freq_busy_nack: assert property (s_freq_write ##0 CHAN_ON != 2'h0
      ##0 run_cnt >= 3'h5 |=> s_refused(STATUS.busy_fault))
      else $error("frequency write while running accepted");
   a_format_read_only: assert property (CMD_VALID && CMD.write
      && CMD.code == 8'h20 && !STATUS_CLEAR |=> s_refused(STATUS.comm_fault))
      else $error("format byte write accepted");
   a_target_below_ceiling: assert property (VOUT_TARGET[0] <= 16'ha200
      && VOUT_TARGET[1] <= 16'ha200)
      else $error("output target above ceiling");
   a_alert_has_cause: assert property (ALERT_OE |-> STATUS[7:1] != 7'h00)
      else $error("alert without status flag");
   a_alert_when_masked: assert property (ALERT_MASK && $past(ALERT_MASK)
      |-> !ALERT_OE)
      else $error("alert driven while masked");
   a_busy_stays_set: assert property (STATUS.busy_fault && !STATUS_CLEAR
      |=> STATUS.busy_fault)
      else $error("busy fault dropped without clear");
   a_alert_data_low: assert property (ALERT_DO == 1'b0)
      else $error("alert data not low");
endmodule // scfg_bank_assertions

bind scfg_bank scfg_bank_assertions scfg_bank_assertions_i (.REF_CLK,
   .SRST, .CMD_VALID, .CMD, .RSP_VALID, .RSP, .RUN_PIN, .CHAN_ON,
   .ALERT_MASK, .STATUS_CLEAR, .VOUT_TARGET, .STATUS, .ALERT_DO, .ALERT_OE);

// File: tb/scfg_host.sv
`timescale 1ns/1ps
module scfg_host (
   input wire logic clk,
   input wire logic rsp_valid,
   input wire scfg_pkg::scfg_rsp_type rsp,
   output logic cmd_valid,
   output scfg_pkg::scfg_cmd_type cmd
);
   // idle bus at time zero
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
   end

   // one transfer; answer stays unknown if it never comes
   task automatic xfer(input logic wr, input logic pg, input logic [7:0] c,
      input logic [15:0] wd, output scfg_pkg::scfg_rsp_type got);
      got = {1'bx, 16'hxxxx};
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd <= {wr, pg, c, wd};
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd <= ~{wr, pg, c, wd}; // released fields must not look stale
      for (int i = 0; i < 4; i++) begin
         #1;
         if (rsp_valid === 1'b1) begin
            got = rsp;
            break;
         end
         @(posedge clk);
      end
   endtask
endmodule // scfg_host

// File: tb/scfg_bank_test.sv
`timescale 1ns/1ps
module scfg_bank_test;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic cmd_valid;
   scfg_pkg::scfg_cmd_type cmd;
   logic rsp_valid;
   scfg_pkg::scfg_rsp_type rsp;
   scfg_pkg::scfg_rsp_type got;
   logic run_pin = 1'b0;
   logic [1:0] chan_on = 2'h0;
   logic [15:0] vin = 16'hcb20;
   logic alert_mask = 1'b1;
   logic status_clear = 1'b0;
   logic [15:0] freq;
   scfg_pkg::scfg_phase_type phase;
   logic [1:0][15:0] target;
   logic conv;
   scfg_pkg::scfg_status_type st;
   logic alert_oe;
   logic [1:0] mhi = 2'h0;
   logic [15:0] filt;
   wire logic [3:0] pb;
   int n_mismatch = 0;
   int samples_checked = 0;
   logic [7:0] codes [15] = '{8'h20, 8'h21, 8'h24, 8'h25, 8'h26, 8'h35,
      8'h36, 8'h40, 8'h42, 8'h43, 8'h44, 8'h55, 8'h58, 8'ha5, 8'hf7};
   logic [15:0] defs [15] = '{16'h0016, 16'h1400, 16'ha000, 16'h1500,
      16'h1300, 16'hcb40, 16'hcb00, 16'h1600, 16'h1580, 16'h1280, 16'h1200,
      16'he300, 16'hcb26, 16'ha200, 16'h0be8};
   logic [17:0] ph [8] = '{18'h000b4, 18'h0b50e, 18'h000f0, 18'h00078,
      18'h0f0f0, 18'h078f0, 18'h0f12c, 18'h000b4};

   always #2 clk = ~clk;

   scfg_host scfg_host_i (.clk(clk), .rsp_valid(rsp_valid), .rsp(rsp),
      .cmd_valid(cmd_valid), .cmd(cmd));
   scfg_bank scfg_bank_i (.REF_CLK(clk), .SRST(srst), .CMD_VALID(cmd_valid),
      .CMD(cmd), .RSP_VALID(rsp_valid), .RSP(rsp), .RUN_PIN(run_pin),
      .CHAN_ON(chan_on), .MARGIN_HIGH_SEL(mhi), .MARGIN_LOW_SEL(2'h0),
      .VIN_MEAS(vin), .PLL_LOCKED(1'b1), .ALERT_MASK(alert_mask),
      .STATUS_CLEAR(status_clear), .SWITCH_FREQ_KHZ(freq), .PHASE(phase),
      .SHARED_FEEDBACK(pb[3]), .SENSE_GAIN(pb[2:1]), .SHARE_CLK_ENABLE(pb[0]),
      .INPUT_FILTER_RES(filt), .VOUT_TARGET(target), .CONVERT_EN(conv),
      .STATUS(st), .ALERT_DO(), .ALERT_OE(alert_oe));

   // compare and count; unknowns never match
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [7:0] c, input logic pg, input logic [15:0] e);
      scfg_host_i.xfer(1'b0, pg, c, 16'h0000, got);
      check({got.ack, got.rdata}, {1'b1, e});
   endtask
   task automatic wr(input logic [7:0] c, input logic pg, input logic [15:0] d,
      input logic ok);
      scfg_host_i.xfer(1'b1, pg, c, d, got);
      check(got.ack, ok);
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic clr;
      @(posedge clk);
      status_clear <= 1'b1;
      @(posedge clk);
      status_clear <= 1'b0;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 15; i++) rd(codes[i], 1'b1, defs[i]);
      scfg_host_i.xfer(1'b0, 1'b0, 8'h99, 16'h0000, got);
      check({got.ack, got.rdata, st.comm_fault}, 18'h00001);
      $display("test defaults done");
      wr(8'h20, 1'b0, 16'h0000, 1'b0);
      wr(8'ha5, 1'b0, 16'h0000, 1'b0);
      rd(8'h20, 1'b0, 16'h0016);
      wr(8'h21, 1'b1, 16'h1450, 1'b1);
      rd(8'h21, 1'b0, 16'h1400);
      step(1);
      check(target[1], 16'h1450);
      wr(8'h55, 1'b1, 16'he310, 1'b1);
      rd(8'h55, 1'b0, 16'he310);
      wr(8'h55, 1'b0, 16'he300, 1'b1);
      clr;
      wr(8'h21, 1'b0, 16'ha300, 1'b1);
      rd(8'h21, 1'b0, 16'ha200);
      check({st.comm_fault, st.output_upper_limit_warn}, 3'b101);
      wr(8'h24, 1'b0, 16'h1000, 1'b1);
      step(2);
      check(target[0], 16'h1000);
      wr(8'h25, 1'b0, 16'ha210, 1'b1);
      wr(8'h26, 1'b0, 16'h1200, 1'b1);
      @(posedge clk);
      mhi <= 2'h1;
      step(2);
      check(target[0], 16'h1000);
      wr(8'hf7, 1'b0, 16'h0000, 1'b1);
      rd(8'hf7, 1'b1, 16'h0000);
      check(filt, 16'h0000);
      $display("test output words done");
      for (int k = 0; k < 8; k++) begin
         wr(8'he0, 1'b0, 16'(k) | 16'h0030, 1'b1);
         step(1);
         check(phase, ph[k]);
      end
      check(pb, 4'h3);
      $display("test phase done");
      clr;
      wr(8'he1, 1'b0, 16'h0054, 1'b0);
      wr(8'he1, 1'b0, 16'h0055, 1'b1);
      wr(8'he1, 1'b0, 16'h01f5, 1'b0);
      wr(8'he1, 1'b0, 16'h01f4, 1'b1);
      check({st.comm_fault, st.pll_unlock}, 2'b11);
      rd(8'he1, 1'b0, 16'h01f4);
      @(posedge clk);
      run_pin <= 1'b1;
      chan_on <= 2'h1;
      step(6);
      wr(8'he1, 1'b0, 16'h0064, 1'b0);
      wr(8'he0, 1'b0, 16'h0000, 1'b0);
      check(st.busy_fault, 1'b1);
      rd(8'he1, 1'b0, 16'h01f4);
      @(posedge clk);
      chan_on <= 2'h0;
      wr(8'he1, 1'b0, 16'h00fa, 1'b1);
      @(posedge clk);
      run_pin <= 1'b0;
      chan_on <= 2'h3;
      step(6);
      wr(8'he1, 1'b0, 16'h0064, 1'b1);
      step(1);
      check(freq, 16'h0064);
      $display("test frequency done");
      clr;
      step(3);
      check({conv, st.input_uv_warn}, 2'b00);
      @(posedge clk);
      run_pin <= 1'b1;
      vin <= 16'hd200;
      step(6);
      check(conv, 1'b1);
      @(posedge clk);
      vin <= 16'hcb20;
      step(3);
      check({st.input_uv_warn, st.word_input, alert_oe}, 3'b110);
      @(posedge clk);
      alert_mask <= 1'b0;
      step(2);
      check(alert_oe, 1'b1);
      @(posedge clk);
      vin <= 16'hcac0;
      step(3);
      check(conv, 1'b0);
      @(posedge clk);
      vin <= 16'he320;
      step(2);
      check(st.input_ov_fault, 1'b1);
      $display("test input done");
      close_out();
   end
endmodule // scfg_bank_test
